// File: bench/bus_nodes_model.sv
`timescale 1ns/1ps
// the other bus nodes: wired lines, echo of our drivers, fault injection
module bus_nodes_model
  import bus_err_pkg::*;
#(
  parameter int NODES = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic de_o,
  input wire logic de_oe_n,
  input wire logic ff_o,
  input wire logic ff_oe_n,
  input wire logic req_o,
  input wire logic [2:0] nid,
  input wire addr_bus_t adr_o,
  input wire logic adr_oe_n,
  input wire logic ack_o,
  input wire logic ack_oe_n,
  input wire logic arb_o,
  input wire logic arb_oe_n,
  input wire logic other_de,
  input wire logic other_ff,
  input wire logic bad_req,
  input wire logic bad_adr,
  input wire logic drop_ack,
  input wire logic drop_arb,
  output logic de_i,
  output logic ff_i,
  output logic [NODES-1:0] req_i,
  output addr_bus_t adr_i,
  output logic ack_i,
  output logic arb_i
);
  logic [1:0] ff_cnt;
  addr_bus_t adr_last;
  // another node's fault lasts two cycles and starts only on an idle line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ff_cnt <= 2'h0;
      adr_last <= '0;
    end else begin
      if (ff_cnt != 2'h0)
        ff_cnt <= ff_cnt - 2'h1;
      else if (other_ff && !ff_i)
        ff_cnt <= 2'h2;
      if (!adr_oe_n)
        adr_last <= adr_o;
    end
  end
  // wired lines; a released address bus shows the inverse of its last value
  always_comb begin
    de_i = (de_o && !de_oe_n) || other_de;
    ff_i = (ff_o && !ff_oe_n) || (ff_cnt != 2'h0);
    req_i = '0;
    req_i[nid] = req_o ^ bad_req;
    adr_i = addr_bus_t'(adr_oe_n ? ~adr_last : (adr_o ^ {43'h0, bad_adr}));
    ack_i = ack_o && !ack_oe_n && !drop_ack;
    arb_i = arb_o && !arb_oe_n && !drop_arb;
  end
endmodule // bus_nodes_model

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import bus_err_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  xfer_t xfer = '0;
  logic [255:0] dbus = '0;
  logic [31:0] ecc = 32'h0;
  logic [11:0] fsrc = 12'h0;
  logic mmr = 1'b0;
  logic nack = 1'b0;
  logic [7:0] cnf = 8'h0;
  logic [7:0] snf = 8'h0;
  logic [31:0] dvec = 32'h0;
  logic breq = 1'b1;
  logic areq = 1'b0;
  addr_bus_t atx = '0;
  logic kreq = 1'b1;
  logic sreq = 1'b1;
  logic [5:0] inj = 6'h0; // other de, other fault, req, adr, ack, arb
  logic de_i, de_o, de_oe_n, ff_i, ff_o, ff_oe_n, req_o, adr_oe_n;
  logic ack_i, ack_o, ack_oe_n, arb_i, arb_o, arb_oe_n, abort, ready, post;
  logic [7:0] rq;
  addr_bus_t adr_o, adr_i;
  logic [31:0] seed = 32'h52ae5c2c;
  int fails = 0;
  int comparisons = 0;

  always #5 hclk = ~hclk;

  bus_err_bcast dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .xfer_i(xfer), .data_bus_i(dbus), .ecc_bus_i(ecc),
    .data_error_line_i(de_i), .data_error_line_o(de_o),
    .data_error_line_oe_n(de_oe_n), .fatal_fault_line_i(ff_i),
    .fatal_fault_line_o(ff_o), .fatal_fault_line_oe_n(ff_oe_n),
    .fatal_src_i(fsrc), .mmr_err_i(mmr), .csr_nack_i(nack),
    .ctrl_nf_src_i(cnf), .slice_nf_src_i(snf), .device_vector_i(dvec),
    .bus_req_i(breq), .request_line_o(req_o), .request_lines_i(rq),
    .node_id_pins(3'h5), .addr_req_i(areq), .addr_tx_i(atx),
    .addr_bus_o(adr_o), .addr_bus_oe_n(adr_oe_n), .addr_bus_i(adr_i),
    .cmd_ack_req_i(kreq), .command_ack_line_i(ack_i),
    .command_ack_line_o(ack_o), .command_ack_line_oe_n(ack_oe_n),
    .arb_sup_req_i(sreq), .arb_suppress_line_i(arb_i),
    .arb_suppress_line_o(arb_o), .arb_suppress_line_oe_n(arb_oe_n),
    .bus_abort(abort), .bus_ready(ready), .err_intr_post(post)
  );

  bus_nodes_model far_u (
    .hclk(hclk), .hresetn(hresetn), .de_o(de_o), .de_oe_n(de_oe_n),
    .ff_o(ff_o), .ff_oe_n(ff_oe_n), .req_o(req_o), .nid(3'h5),
    .adr_o(adr_o), .adr_oe_n(adr_oe_n), .ack_o(ack_o), .ack_oe_n(ack_oe_n),
    .arb_o(arb_o), .arb_oe_n(arb_oe_n), .other_de(inj[0]),
    .other_ff(inj[1]), .bad_req(inj[2]), .bad_adr(inj[3]),
    .drop_ack(inj[4]), .drop_arb(inj[5]), .de_i(de_i), .ff_i(ff_i),
    .req_i(rq), .adr_i(adr_i), .ack_i(ack_i), .arb_i(arb_i)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one single word transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  // two data cycles of random data; records when our error line pulses
  task automatic xfr(input logic part, input logic tx, input logic oth,
                     output int at, output int n);
    n = 0;
    at = 0;
    seed = lfsr(seed);
    xfer <= {1'b1, 1'b1, part, tx, 1'b0};
    dbus <= {8{seed}};
    ecc <= ~seed;
    @(posedge hclk);
    xfer.first <= 1'b0;
    @(posedge hclk);
    xfer <= '0;
    // sample mid-cycle so the registered pulse is settled
    for (int k = 2; k < 14; k++) begin
      inj[0] <= oth && (k == 10);
      @(negedge hclk);
      if (de_o === 1'b1) begin
        n++;
        at = k;
      end
      @(posedge hclk);
    end
  endtask

  // follows one fault from its onset through the recovery window
  task automatic fwatch(output int hi, output int lo, output int bad);
    int k0;
    hi = 1;
    lo = 0;
    bad = 0;
    k0 = 0;
    // look mid-cycle, starting in the cycle the stimulus was applied
    @(negedge hclk);
    while (ff_i !== 1'b1 && k0 < 8) begin
      @(negedge hclk);
      k0++;
    end
    if (abort !== 1'b1) bad++;
    for (int k = 1; k < 37; k++) begin
      @(posedge hclk);
      if (k == 1) begin
        fsrc <= 12'h0;
        areq <= 1'b0;
        inj <= 6'h0;
      end
      @(negedge hclk);
      hi += (ff_i === 1'b1);
      lo += (ready !== 1'b1);
      if (k > 1 && k < 33 && req_o !== 1'b0) bad++;
      if (k > 15 && k < 32 && {adr_oe_n, ack_oe_n, arb_oe_n} !== 3'h7) bad++;
      if (k == 36 && req_o !== 1'b1) bad++;
    end
    @(posedge hclk);
  endtask

  // pulses one nonfatal source and counts interrupt posts
  task automatic irq(input int s, output int n);
    n = 0;
    case (s)
      0: mmr <= 1'b1;
      1: nack <= 1'b1;
      2: snf <= 8'h01;
      default: cnf <= 8'h01;
    endcase
    @(posedge hclk);
    mmr <= 1'b0;
    nack <= 1'b0;
    snf <= 8'h0;
    cnf <= 8'h0;
    repeat (8) begin
      @(negedge hclk);
      n += (post === 1'b1);
    end
    @(posedge hclk);
  endtask

  // main sequence
  initial begin
    logic [31:0] r;
    logic e;
    int at, n, hi, lo, bad, b;
    int tc[4] = '{BER_REQUEST_TRANSMIT_CHECK_ERR, BER_ADDRESS_TRANSMIT_CHECK_ERR, BER_ACK_TRANSMIT_CHECK_ERR, BER_ARB_TRANSMIT_CHECK_ERR};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    ahb(1'b0, OFS_CFG, 32'h0, r);
    chk(r, CFG_RST);
    ahb(1'b0, 8'h1c, 32'h0, r);
    chk(r, 32'h0);
    xfr(1'b0, 1'b0, 1'b0, at, n);
    chk(n, 0);
    for (int j = 0; j < 4; j++) begin
      xfr(1'b1, j[0], j[1], at, n);
      ahb(1'b0, OFS_BER, 32'h0, r);
      e = (r[2:0] !== 3'h0);
      chk(n, e);
      chk(at, e ? 10 : 0);
      chk(r[BER_TRANSMITTED_DATA_ERROR], j[0] && (j[1] || e));
      ahb(1'b1, OFS_BER, 32'hffffffff, r);
    end
    atx <= addr_bus_t'({seed, 12'h5a3});
    for (int i = 0; i < 16; i++) begin
      b = (i < 12) ? BER_FATAL_LO + i : tc[i - 12];
      if (i < 12)
        fsrc <= 12'h1 << i;
      else
        inj[i - 10] <= 1'b1;
      areq <= (i == 13);
      fwatch(hi, lo, bad);
      chk(hi, 2);
      chk(lo, 31);
      chk(bad, 0);
      ahb(1'b0, OFS_BER, 32'h0, r);
      chk(r, 32'h1 << b);
      ahb(1'b1, OFS_BER, 32'hffffffff, r);
    end
    inj[1] <= 1'b1;
    @(posedge hclk);
    inj[1] <= 1'b0;
    fsrc <= 12'h001;
    fwatch(hi, lo, bad);
    chk(hi, 2);
    chk(bad, 0);
    ahb(1'b1, OFS_BER, 32'hffffffff, r);
    seed = lfsr(seed);
    dvec <= seed;
    ahb(1'b0, OFS_L17, 32'h0, r);
    chk(r, seed);
    ahb(1'b1, OFS_VEC, 32'h000005a0, r);
    ahb(1'b0, OFS_VEC, 32'h0, r);
    chk(r, 32'h000005a0);
    ahb(1'b1, OFS_CNF, 32'h800000ff, r);
    irq(0, n);
    chk(n, 1);
    irq(1, n);
    chk(n, 0);
    ahb(1'b0, OFS_L17, 32'h0, r);
    chk(r, 32'h000005a0);
    ahb(1'b1, OFS_BER, 32'h00000030, r);
    irq(2, n);
    chk(n, 1);
    ahb(1'b1, OFS_SNF, 32'h000000ff, r);
    irq(3, n);
    chk(n, 1);
    tally_and_finish();
  end

  // watchdog well beyond the expected run length
  initial begin
    #50000;
    fails++;
    tally_and_finish();
  end
endmodule // testbench

// File: logic/bus_err_bcast.sv
// Function
// - broadcast data-error line on correctable read, write or uncorrectable ECC
// - correctable read and write broadcasts each have a disable bit
// - check data only when participating as sender or receiver
// - each slice checks 64 data with 8 ECC, logs, tells controller
// - data-error line high one cycle, tenth cycle after first data cycle
// - set transmitted-data-error when line high for our transmitted data
// - drive fatal-fault line on all fatal error sources
// - fatal-fault line held exactly two cycles, never extended
// - on fatal fault abort everything, return interface to initial state
// - release request line within two cycles of fatal fault
// - release other driven bus signals within 16 cycles of fault
// - no bus request until 32 cycles after a fault
// - nonfatal error sources raise the error interrupt, some gated
// - port power-good transitions and link errors interrupt likewise
// - vector loaded before enable; once enabled, errors post interrupt
// - no further error interrupt until all nonfatal error status bits clear
// - level-17 id read returns error vector before device vectors
// - level check compares received to driven level both ways
// - assertion check flags only driven-high, received-low
// - level-check address, parity, command and bank after driving them
// - level-check own request line every cycle, set check bit
// - assertion-check own acknowledge and arbitration-suppress lines
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module bus_err_bcast
  import bus_err_pkg::*;
#(
  parameter int NODES = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire xfer_t xfer_i,
  input wire logic [255:0] data_bus_i,
  input wire logic [31:0] ecc_bus_i,
  input wire logic data_error_line_i,
  output logic data_error_line_o,
  output logic data_error_line_oe_n,
  input wire logic fatal_fault_line_i,
  output logic fatal_fault_line_o,
  output logic fatal_fault_line_oe_n,
  input wire logic [FATAL_N-1:0] fatal_src_i,
  input wire logic mmr_err_i,
  input wire logic csr_nack_i,
  input wire logic [NF_N-1:0] ctrl_nf_src_i,
  input wire logic [NF_N-1:0] slice_nf_src_i,
  input wire logic [31:0] device_vector_i,
  input wire logic bus_req_i,
  output logic request_line_o,
  input wire logic [NODES-1:0] request_lines_i,
  input wire logic [2:0] node_id_pins,
  input wire logic addr_req_i,
  input wire addr_bus_t addr_tx_i,
  output addr_bus_t addr_bus_o,
  output logic addr_bus_oe_n,
  input wire addr_bus_t addr_bus_i,
  input wire logic cmd_ack_req_i,
  input wire logic command_ack_line_i,
  output logic command_ack_line_o,
  output logic command_ack_line_oe_n,
  input wire logic arb_sup_req_i,
  input wire logic arb_suppress_line_i,
  output logic arb_suppress_line_o,
  output logic arb_suppress_line_oe_n,
  output logic bus_abort,
  output logic bus_ready,
  output logic err_intr_post
);

  if (NODES < 2 || NODES > 8) begin : g_chk
    $error("NODES must lie between 2 and 8");
  end

  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] ber;
    logic [31:0] cnf;
    logic [31:0] snf;
    logic [31:0] vec;
    logic [SLICES*SES_W-1:0] ses;
    logic a_wr;
    logic [7:0] a_ofs;
    logic [31:0] rdata;
    logic de_act;
    logic [3:0] de_cnt;
    logic de_cr;
    logic de_cw;
    logic de_ue;
    logic de_tx;
    logic de_o;
    logic f_seen;
    logic [5:0] f_cnt;
    logic [1:0] f_drv;
    logic f_pend;
    logic posted;
    logic post;
    logic req_o;
    logic adr_drv;
    addr_bus_t adr_o;
    logic ack_o;
    logic arb_o;
    logic [2:0] nid1;
    logic [2:0] nid2;
    logic [1:0] nid_ok;
  } st_t;

  st_t st_reg;
  st_t st_next;

  // hamming code over one 64-bit slice, top bit is overall parity
  function automatic logic [7:0] ecc_gen(input logic [63:0] d);
    logic [7:0] c;
    logic [7:0] p;
    c = 8'h0;
    p = 8'h03;
    for (int j = 0; j < SLICE_DW; j++) begin
      for (int k = 0; k < 7; k++) begin
        if (p[k]) c[k] = c[k] ^ d[j];
      end
      p = p + 8'h01;
      if ((p & (p - 8'h01)) == 8'h0) p = p + 8'h01;
    end
    c[7] = ^{d, c[6:0]};
    return c;
  endfunction

  // per-slice checkers: one correctable or uncorrectable flag each
  logic [SLICES-1:0] sl_ce;
  logic [SLICES-1:0] sl_ue;
  for (genvar s = 0; s < SLICES; s++) begin : g_slice
    logic [7:0] syn;
    assign syn = ecc_gen(data_bus_i[s*SLICE_DW +: SLICE_DW]) ^
                 ecc_bus_i[s*SLICE_EW +: SLICE_EW];
    assign sl_ce[s] = syn[7];
    assign sl_ue[s] = !syn[7] && (syn[6:0] != 7'h0);
  end

  logic chk_en;
  logic ce_any;
  logic ue_any;
  logic onset;
  logic ready;
  logic address_transmit_check_err_ev;
  logic request_transmit_check_err_ev;
  logic ack_ev;
  logic arb_ev;
  logic fatal_ev;
  logic nf_any;
  logic nf_gated;
  logic a_sel;
  logic [31:0] rmux;
  logic [31:0] w1c;

  // bus-side event decode
  always_comb begin
    chk_en = xfer_i.valid && xfer_i.part;
    ce_any = chk_en && (|sl_ce);
    ue_any = chk_en && (|sl_ue);
    onset = fatal_fault_line_i && !st_reg.f_seen;
    ready = (st_reg.f_cnt == REARM_CYC);
    address_transmit_check_err_ev = st_reg.adr_drv && (addr_bus_i != st_reg.adr_o);
    request_transmit_check_err_ev = st_reg.nid_ok[1] &&
              (request_lines_i[st_reg.nid2] != st_reg.req_o);
    ack_ev = st_reg.ack_o && !command_ack_line_i;
    arb_ev = st_reg.arb_o && !arb_suppress_line_i;
    fatal_ev = (|fatal_src_i) || address_transmit_check_err_ev || request_transmit_check_err_ev || ack_ev ||
               arb_ev;
  end

  // nonfatal summary for the error interrupt
  always_comb begin
    nf_any = (|st_reg.ber[BER_NAE:BER_CRDE]) ||
             (|st_reg.cnf[NF_N-1:0]) || (|st_reg.snf[NF_N-1:0]);
    nf_gated = (st_reg.ber[BER_CRDE] && !st_reg.cfg[CFG_CORR_READ_REPORT_DISABLE]) ||
               (st_reg.ber[BER_CWDE] && !st_reg.cfg[CFG_CORR_WRITE_REPORT_DISABLE]) ||
               (|st_reg.ber[BER_NAE:BER_UDE]) ||
               (|(st_reg.cnf[NF_N-1:0] &
                  ~st_reg.cfg[CFG_MASK_LO +: NF_N])) ||
               (|st_reg.snf[NF_N-1:0]);
  end

  // register read mux, taken in the address phase
  always_comb begin
    a_sel = hsel && hready && htrans[1];
    case (haddr[7:0])
      OFS_CFG: rmux = st_reg.cfg;
      OFS_BER: rmux = st_reg.ber;
      OFS_CNF: rmux = st_reg.cnf;
      OFS_SNF: rmux = st_reg.snf;
      OFS_VEC: rmux = st_reg.vec;
      OFS_L17: rmux = st_reg.posted ? st_reg.vec
                                    : device_vector_i;
      OFS_SES: rmux = {{(32 - SLICES*SES_W){1'b0}}, st_reg.ses};
      default: rmux = 32'h0;
    endcase
    if (haddr[31:8] != 24'h0) rmux = 32'h0;
    w1c = st_reg.a_wr ? hwdata : 32'h0;
  end

  // next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.post = 1'b0;
    // address phase capture
    st_next.a_wr = a_sel && hwrite && (haddr[31:8] == 24'h0);
    st_next.a_ofs = haddr[7:0];
    if (a_sel && !hwrite) st_next.rdata = rmux;
    // write data phase: plain stores and write-one-to-clear
    if (st_reg.a_wr) begin
      case (st_reg.a_ofs)
        OFS_CFG: st_next.cfg = hwdata;
        OFS_BER: st_next.ber = st_reg.ber & ~w1c;
        OFS_CNF: begin
          st_next.cnf[NF_N-1:0] = st_reg.cnf[NF_N-1:0] & ~w1c[NF_N-1:0];
          st_next.cnf[CNF_EN] = hwdata[CNF_EN];
        end
        OFS_SNF: st_next.snf = st_reg.snf & ~w1c;
        OFS_VEC: st_next.vec = hwdata;
        OFS_SES: st_next.ses = st_reg.ses & ~w1c[SLICES*SES_W-1:0];
        default: ;
      endcase
    end
    // node id strap through two flops
    st_next.nid1 = node_id_pins;
    st_next.nid2 = st_reg.nid1;
    st_next.nid_ok = {st_reg.nid_ok[0], 1'b1};
    // data transfer tracking from the first data cycle
    if (st_reg.de_act) begin
      st_next.de_cnt = st_reg.de_cnt + 4'h1;
      if (st_reg.de_cnt == DE_CYC) st_next.de_act = 1'b0;
    end
    if (xfer_i.first && xfer_i.valid) begin
      st_next.de_act = 1'b1;
      st_next.de_cnt = 4'h1;
      st_next.de_cr = 1'b0;
      st_next.de_cw = 1'b0;
      st_next.de_ue = 1'b0;
      st_next.de_tx = xfer_i.tx && xfer_i.part;
    end
    // slice logging and controller accumulation
    for (int s = 0; s < SLICES; s++) begin
      if (chk_en && sl_ce[s] && !xfer_i.wr)
        st_next.ses[s*SES_W + SES_CR] = 1'b1;
      if (chk_en && sl_ce[s] && xfer_i.wr)
        st_next.ses[s*SES_W + SES_CW] = 1'b1;
      if (chk_en && sl_ue[s])
        st_next.ses[s*SES_W + SES_UE] = 1'b1;
    end
    if (ce_any && !xfer_i.wr) begin
      st_next.de_cr = 1'b1;
      st_next.ber[BER_CRDE] = 1'b1;
    end
    if (ce_any && xfer_i.wr) begin
      st_next.de_cw = 1'b1;
      st_next.ber[BER_CWDE] = 1'b1;
    end
    if (ue_any) begin
      st_next.de_ue = 1'b1;
      st_next.ber[BER_UDE] = 1'b1;
    end
    // one-cycle broadcast on the tenth cycle after the first data cycle
    st_next.de_o = st_reg.de_act && (st_reg.de_cnt == DE_CYC - 4'h1) &&
                   (st_reg.de_ue ||
                    (st_reg.de_cr && !st_reg.cfg[CFG_CORR_READ_REPORT_DISABLE]) ||
                    (st_reg.de_cw && !st_reg.cfg[CFG_CORR_WRITE_REPORT_DISABLE]));
    if (st_reg.de_act && st_reg.de_cnt == DE_CYC && st_reg.de_tx &&
        data_error_line_i)
      st_next.ber[BER_TRANSMITTED_DATA_ERROR] = 1'b1;
    // fatal and check status
    if (address_transmit_check_err_ev) st_next.ber[BER_ADDRESS_TRANSMIT_CHECK_ERR] = 1'b1;
    if (request_transmit_check_err_ev) st_next.ber[BER_REQUEST_TRANSMIT_CHECK_ERR] = 1'b1;
    if (ack_ev) st_next.ber[BER_ACK_TRANSMIT_CHECK_ERR] = 1'b1;
    if (arb_ev) st_next.ber[BER_ARB_TRANSMIT_CHECK_ERR] = 1'b1;
    st_next.ber[BER_FATAL_LO +: FATAL_N] =
      st_next.ber[BER_FATAL_LO +: FATAL_N] | fatal_src_i;
    if (mmr_err_i) st_next.ber[BER_MMRE] = 1'b1;
    if (csr_nack_i) st_next.ber[BER_NAE] = 1'b1;
    st_next.cnf[NF_N-1:0] = st_next.cnf[NF_N-1:0] | ctrl_nf_src_i;
    st_next.snf[NF_N-1:0] = st_next.snf[NF_N-1:0] | slice_nf_src_i;
    // fault line drive: two cycles, only onto an idle line
    st_next.f_seen = fatal_fault_line_i;
    if (st_reg.f_drv != 2'h0) st_next.f_drv = st_reg.f_drv - 2'h1;
    st_next.f_pend = (st_reg.f_pend || fatal_ev) && ready && !onset;
    if ((st_reg.f_pend || fatal_ev) && ready && !fatal_fault_line_i &&
        st_reg.f_drv == 2'h0) begin
      st_next.f_drv = FAULT_CYC;
      st_next.f_pend = 1'b0;
    end
    // recovery count from the first fault cycle
    if (!ready) st_next.f_cnt = st_reg.f_cnt + 6'h1;
    // bus-side drivers
    st_next.req_o = bus_req_i && ready && !onset;
    st_next.adr_drv = addr_req_i && ready && !onset;
    st_next.adr_o = addr_tx_i;
    st_next.ack_o = cmd_ack_req_i && ready && !onset;
    st_next.arb_o = arb_sup_req_i && ready && !onset;
    if (onset) begin
      st_next.f_cnt = 6'h1;
      st_next.de_act = 1'b0;
      st_next.de_o = 1'b0;
      st_next.req_o = 1'b0;
      st_next.adr_drv = 1'b0;
      st_next.ack_o = 1'b0;
      st_next.arb_o = 1'b0;
    end
    // error interrupt, one post per clean-to-dirty episode
    if (!nf_any) st_next.posted = 1'b0;
    if (st_reg.cnf[CNF_EN] && nf_gated && !st_reg.posted) begin
      st_next.posted = 1'b1;
      st_next.post = 1'b1;
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
      st_reg.cfg <= CFG_RST;
      st_reg.vec <= VEC_RST;
      st_reg.f_cnt <= REARM_CYC;
    end else begin
      st_reg <= st_next;
    end
  end

  // port drive
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_reg.rdata;
  assign data_error_line_o = st_reg.de_o;
  assign data_error_line_oe_n = !st_reg.de_o;
  assign fatal_fault_line_o = (st_reg.f_drv != 2'h0);
  assign fatal_fault_line_oe_n = (st_reg.f_drv == 2'h0);
  assign request_line_o = st_reg.req_o;
  assign addr_bus_o = st_reg.adr_o;
  assign addr_bus_oe_n = !st_reg.adr_drv;
  assign command_ack_line_o = st_reg.ack_o;
  assign command_ack_line_oe_n = !st_reg.ack_o;
  assign arb_suppress_line_o = st_reg.arb_o;
  assign arb_suppress_line_oe_n = !st_reg.arb_o;
  assign bus_abort = onset;
  assign bus_ready = ready;
  assign err_intr_post = st_reg.post;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_de_one;
    data_error_line_o |=> !data_error_line_o;
  endproperty
  a_de_one: assert property (p_de_one)
    else $error("data error line longer than one cycle");

  property p_de_time;
    data_error_line_o |-> $past(xfer_i.first && xfer_i.valid, 10);
  endproperty
  a_de_time: assert property (p_de_time)
    else $error("data error not on tenth cycle");

  property p_fault_two;
    $rose(fatal_fault_line_o) |=> fatal_fault_line_o ##1 !fatal_fault_line_o;
  endproperty
  a_fault_two: assert property (p_fault_two)
    else $error("fault drive not two cycles");

  property p_fault_idle;
    $rose(fatal_fault_line_o) |-> !$past(fatal_fault_line_i);
  endproperty
  a_fault_idle: assert property (p_fault_idle)
    else $error("fault drive extends another node");

  property p_req_rel;
    $rose(fatal_fault_line_i) |-> ##[1:2] !request_line_o;
  endproperty
  a_req_rel: assert property (p_req_rel)
    else $error("request not released in time");

  property p_sig_rel;
    $rose(fatal_fault_line_i) |->
      ##[1:16] (addr_bus_oe_n && !command_ack_line_o && !arb_suppress_line_o);
  endproperty
  a_sig_rel: assert property (p_sig_rel)
    else $error("bus signals not released in time");

  property p_req_wait;
    $rose(fatal_fault_line_i) |-> ##31 !request_line_o;
  endproperty
  a_req_wait: assert property (p_req_wait)
    else $error("request within 32 cycles of fault");

  property p_address_transmit_check_err;
    (st_reg.adr_drv && addr_bus_i != addr_bus_o) |=> st_reg.ber[BER_ADDRESS_TRANSMIT_CHECK_ERR];
  endproperty
  a_address_transmit_check_err: assert property (p_address_transmit_check_err)
    else $error("address check bit not set");

  property p_ack;
    (command_ack_line_o && !command_ack_line_i) |=> st_reg.ber[BER_ACK_TRANSMIT_CHECK_ERR];
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge check bit not set");

  property p_post;
    err_intr_post |-> $past(st_reg.cnf[CNF_EN]) ##1 !err_intr_post;
  endproperty
  a_post: assert property (p_post)
    else $error("interrupt posted while disabled");

endmodule // bus_err_bcast

// File: logic/bus_err_pkg.sv
package bus_err_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_BER = 8'h04;
  localparam logic [7:0] OFS_CNF = 8'h08;
  localparam logic [7:0] OFS_SNF = 8'h0c;
  localparam logic [7:0] OFS_VEC = 8'h10;
  localparam logic [7:0] OFS_L17 = 8'h14;
  localparam logic [7:0] OFS_SES = 8'h18;
  // reset values
  localparam logic [31:0] CFG_RST = 32'h0;
  localparam logic [31:0] VEC_RST = 32'h0;
  // bus config fields
  localparam int CFG_CORR_READ_REPORT_DISABLE = 0;
  localparam int CFG_CORR_WRITE_REPORT_DISABLE = 1;
  localparam int CFG_MASK_LO = 8;
  // bus error fields
  localparam int BER_CRDE = 0;
  localparam int BER_CWDE = 1;
  localparam int BER_UDE = 2;
  localparam int BER_TRANSMITTED_DATA_ERROR = 3;
  localparam int BER_MMRE = 4;
  localparam int BER_NAE = 5;
  localparam int BER_ADDRESS_TRANSMIT_CHECK_ERR = 6;
  localparam int BER_REQUEST_TRANSMIT_CHECK_ERR = 7;
  localparam int BER_ACK_TRANSMIT_CHECK_ERR = 8;
  localparam int BER_ARB_TRANSMIT_CHECK_ERR = 9;
  localparam int BER_FATAL_LO = 16;
  localparam int FATAL_N = 12;
  // nonfatal registers
  localparam int CNF_EN = 31;
  localparam int NF_N = 8;
  // slice flags, three per slice
  localparam int SES_CR = 0;
  localparam int SES_CW = 1;
  localparam int SES_UE = 2;
  localparam int SES_W = 3;
  // timing in bus cycles
  localparam logic [3:0] DE_CYC = 4'ha;
  localparam logic [1:0] FAULT_CYC = 2'h2;
  localparam int REQ_REL_CYC = 2;
  localparam int SIG_REL_CYC = 16;
  localparam logic [5:0] REARM_CYC = 6'h20;
  // data slicing
  localparam int SLICES = 4;
  localparam int SLICE_DW = 64;
  localparam int SLICE_EW = 8;

  typedef struct packed {
    logic [39:5] adr;
    logic [1:0] par;
    logic [2:0] cmd;
    logic [3:0] bank;
  } addr_bus_t;

  typedef struct packed {
    logic first;
    logic valid;
    logic part;
    logic tx;
    logic wr;
  } xfer_t;
endpackage
